// File: rtl/bbc_params.svh
`ifndef BBC_PARAMS_SVH
`define BBC_PARAMS_SVH

// Register indices; the bus byte address is four times the index
`define BBC_IDX_RATE 8'h38
`define BBC_IDX_POL 8'h39
`define BBC_IDX_CCC 8'h40

// Writable bits of each register, all others are reserved
`define BBC_RATE_WMASK 8'h01
`define BBC_POL_WMASK 8'h04
`define BBC_CCC_WMASK 8'hfc

// Reset values
`define BBC_RATE_RST 8'h00
`define BBC_POL_RST 8'h00
`define BBC_CCC_RST 8'h48

// Field positions
`define BBC_TURBO_BIT 0
`define BBC_INV_BIT 2
`define BBC_MODE_HI 7
`define BBC_MODE_LO 6
`define BBC_CSTH_HI 5
`define BBC_CSTH_LO 2

// Timing
`define BBC_CLK_KHZ 40000
`define BBC_STD_RATE_KBPS 250
`define BBC_HI_RATE_KBPS 625

`endif

// File: rtl/bbc_pkg.sv
package bbc_pkg;
	typedef enum logic [1:0] {
		BBC_CC_RSVD = 2'b00,
		BBC_CC_CS = 2'b01,
		BBC_CC_ED = 2'b10,
		BBC_CC_CS_ED = 2'b11
	} bbc_ccmode_t;
endpackage

// File: rtl/bbc_cc_if.sv
`timescale 1ns/1ps
interface bbc_cc_if;
	import bbc_pkg::*;
	bbc_ccmode_t mode;
	logic [3:0] cs_th;
	logic [3:0] cs_level;
	logic [7:0] ed_level;
	logic [7:0] ed_th;
	logic busy;
	modport cfg (output mode, output cs_th, output cs_level, output ed_level, output ed_th, input busy);
	modport chk (input mode, input cs_th, input cs_level, input ed_level, input ed_th, output busy);
endinterface

// File: rtl/bbc_chan_check.sv
`timescale 1ns/1ps
module bbc_chan_check
(
	input wire logic clk_i,
	input wire logic rst_i,
	bbc_cc_if.chk cc
);
	import bbc_pkg::*;

	logic busy_ff;
	logic nxt_busy;
	logic carrier;
	logic energy;

	// Both detectors are strict comparisons against their thresholds
	assign carrier = cc.cs_level > cc.cs_th;
	assign energy = cc.ed_level > cc.ed_th;

	// Busy decision per mode; reserved code falls back to carrier sense
	always_comb
	begin
		nxt_busy = 1'b0;
		unique case (cc.mode)
			BBC_CC_ED: nxt_busy = energy;
			BBC_CC_CS_ED: nxt_busy = carrier & energy;
			BBC_CC_CS: nxt_busy = carrier;
			BBC_CC_RSVD: nxt_busy = carrier;
		endcase
	end

	// Registered so the busy flag is glitch free
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			busy_ff <= 1'b0;
		else
			busy_ff <= nxt_busy;
	end

	assign cc.busy = busy_ff;
endmodule

// File: rtl/bbc_config.sv
`timescale 1ns/1ps
`include "bbc_params.svh"
// Operation
// - Rate bit set: baseband tick runs at 625 kbps.
// - Rate bit clear, the reset value: standard 250 kbps operation.
// - Sign-invert bit set: each decoded receive symbol is negated.
// - Sign-invert bit resets to 0; then symbols pass unchanged.
// - Mode 10: busy whenever energy exceeds the energy threshold.
// - Mode 11: busy only with carrier sensed and energy above threshold.
module bbc_config
#(
	parameter int SYM_W = 8
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic signed [SYM_W-1:0] rx_sym_i,
	input wire logic rx_sym_valid_i,
	output logic signed [SYM_W-1:0] rx_sym_o,
	output logic rx_sym_valid_o,
	input wire logic [3:0] cs_level_i,
	input wire logic [7:0] ed_level_i,
	input wire logic [7:0] ed_threshold_i,
	output logic channel_busy_o,
	output logic high_rate_o,
	output logic bit_tick_o
);
	import bbc_pkg::*;

	bbc_cc_if cc_bus();

	logic [7:0] rate_ff;
	logic [7:0] nxt_rate;
	logic [7:0] pol_ff;
	logic [7:0] nxt_pol;
	logic [7:0] ccc_ff;
	logic [7:0] nxt_ccc;
	logic ack_ff;
	logic nxt_ack;
	logic [7:0] rdat_ff;
	logic [7:0] nxt_rdat;
	logic [7:0] div_ff;
	logic [7:0] nxt_div;
	logic tick_ff;
	logic nxt_tick;
	logic turbo_ff;
	logic nxt_turbo;
	logic signed [SYM_W-1:0] sym_ff;
	logic signed [SYM_W-1:0] nxt_sym;
	logic sym_vld_ff;
	logic nxt_sym_vld;
	logic req;
	logic wr_now;
	logic [7:0] idx;

	// Cycles per bit period at a given rate, truncated
	function automatic logic [7:0] div_cycles(input int kbps);
		int c;
		c = `BBC_CLK_KHZ / kbps;
		return c[7:0];
	endfunction

	// Register index match on word address
	function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
		return a == i;
	endfunction

	assign req = wb_cyc_i & wb_stb_i;
	// Word index; the two byte-lane address bits are ignored
	assign idx = wb_adr_i[9:2];
	// Write lands on the edge where the master sees ack
	assign wr_now = req & wb_we_i & ack_ff & wb_sel_i[0];

	// Bus answer: ack one cycle after request, dropped the cycle after
	always_comb
	begin
		nxt_ack = req & ~ack_ff;
		nxt_rdat = 8'h00;
		if (hit(idx, `BBC_IDX_RATE))
			nxt_rdat = rate_ff;
		else if (hit(idx, `BBC_IDX_POL))
			nxt_rdat = pol_ff;
		else if (hit(idx, `BBC_IDX_CCC))
			nxt_rdat = ccc_ff;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= 8'h00;
		end
		else
		begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	// Register writes; reserved bits are masked so they always read zero
	always_comb
	begin
		nxt_rate = rate_ff;
		nxt_pol = pol_ff;
		nxt_ccc = ccc_ff;
		if (wr_now && hit(idx, `BBC_IDX_RATE))
			nxt_rate = wb_dat_i[7:0] & `BBC_RATE_WMASK;
		if (wr_now && hit(idx, `BBC_IDX_POL))
			nxt_pol = wb_dat_i[7:0] & `BBC_POL_WMASK;
		if (wr_now && hit(idx, `BBC_IDX_CCC))
			nxt_ccc = wb_dat_i[7:0] & `BBC_CCC_WMASK;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rate_ff <= `BBC_RATE_RST;
			pol_ff <= `BBC_POL_RST;
			ccc_ff <= `BBC_CCC_RST;
		end
		else
		begin
			rate_ff <= nxt_rate;
			pol_ff <= nxt_pol;
			ccc_ff <= nxt_ccc;
		end
	end

	// Bit-rate divider; a rate change restarts the period at once
	always_comb
	begin
		nxt_turbo = rate_ff[`BBC_TURBO_BIT];
		nxt_tick = 1'b0;
		if (nxt_turbo != turbo_ff || div_ff == 8'h00)
		begin
			nxt_tick = (div_ff == 8'h00) & (nxt_turbo == turbo_ff);
			if (nxt_turbo)
				nxt_div = div_cycles(`BBC_HI_RATE_KBPS) - 8'h01;
			else
				nxt_div = div_cycles(`BBC_STD_RATE_KBPS) - 8'h01;
		end
		else
			nxt_div = div_ff - 8'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			turbo_ff <= 1'b0;
			div_ff <= 8'h00;
			tick_ff <= 1'b0;
		end
		else
		begin
			turbo_ff <= nxt_turbo;
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end

	// Symbol sign path; most negative code wraps on negation
	always_comb
	begin
		nxt_sym_vld = rx_sym_valid_i;
		nxt_sym = sym_ff;
		if (rx_sym_valid_i)
		begin
			if (pol_ff[`BBC_INV_BIT])
				nxt_sym = -rx_sym_i;
			else
				nxt_sym = rx_sym_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sym_ff <= '0;
			sym_vld_ff <= 1'b0;
		end
		else
		begin
			sym_ff <= nxt_sym;
			sym_vld_ff <= nxt_sym_vld;
		end
	end

	// Channel check configuration feeds the decision module
	assign cc_bus.mode = bbc_ccmode_t'(ccc_ff[`BBC_MODE_HI:`BBC_MODE_LO]);
	assign cc_bus.cs_th = ccc_ff[`BBC_CSTH_HI:`BBC_CSTH_LO];
	assign cc_bus.cs_level = cs_level_i;
	assign cc_bus.ed_level = ed_level_i;
	assign cc_bus.ed_th = ed_threshold_i;

	bbc_chan_check u_check
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cc(cc_bus.chk)
	);

	// Outputs
	assign wb_dat_o = {24'h000000, rdat_ff};
	assign wb_ack_o = ack_ff;
	assign rx_sym_o = sym_ff;
	assign rx_sym_valid_o = sym_vld_ff;
	assign channel_busy_o = cc_bus.busy;
	assign high_rate_o = turbo_ff;
	assign bit_tick_o = tick_ff;
endmodule

// File: tb/bbc_config_asserts.sv
`timescale 1ns/1ps
`include "bbc_params.svh"
module bbc_config_asserts
#(
	parameter int SYM_W = 8
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic signed [SYM_W-1:0] rx_sym_i,
	input wire logic rx_sym_valid_i,
	input wire logic signed [SYM_W-1:0] rx_sym_o,
	input wire logic rx_sym_valid_o,
	input wire logic [3:0] cs_level_i,
	input wire logic [7:0] ed_level_i,
	input wire logic [7:0] ed_threshold_i,
	input wire logic channel_busy_o,
	input wire logic high_rate_o,
	input wire logic bit_tick_o
);
	logic inv_ff, nxt_inv, wr, cs_hit, ed_hit;
	logic [7:0] ccc_ff, nxt_ccc;
	// Shadow config, taken at the acked write edge like the design
	always_comb
	begin
		wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
		nxt_inv = (wr && wb_adr_i[9:2] == `BBC_IDX_POL) ? wb_dat_i[2] : inv_ff;
		nxt_ccc = (wr && wb_adr_i[9:2] == `BBC_IDX_CCC) ? (wb_dat_i[7:0] & `BBC_CCC_WMASK) : ccc_ff;
		cs_hit = cs_level_i > ccc_ff[5:2];
		ed_hit = ed_level_i > ed_threshold_i;
	end
	always_ff @(posedge clk_i)
	begin
		inv_ff <= rst_i ? 1'h0 : nxt_inv;
		ccc_ff <= rst_i ? `BBC_CCC_RST : nxt_ccc;
	end
	// Cycles since the last tick; after a rate change the next gap is a restart, not a period
	logic [7:0] gap_ff;
	logic hr_ff, fresh_ff;
	always_ff @(posedge clk_i)
	begin
		hr_ff <= high_rate_o;
		gap_ff <= (rst_i || bit_tick_o) ? 8'h01 : gap_ff + 8'h01;
		fresh_ff <= (rst_i || hr_ff != high_rate_o) ? 1'b1 : bit_tick_o ? 1'b0 : fresh_ff;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_fast_tick: assert property (bit_tick_o && high_rate_o |-> ##64 (bit_tick_o || !high_rate_o))
		else $error("fast tick period wrong");
	a_std_tick: assert property (bit_tick_o && !high_rate_o |-> ##160 (bit_tick_o || high_rate_o))
		else $error("standard tick period wrong");
	a_tick_gap: assert property (bit_tick_o && !fresh_ff |-> gap_ff == (high_rate_o ? 8'h40 : 8'ha0))
		else $error("tick gap wrong");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_sym_neg: assert property (rx_sym_valid_i && inv_ff |=> rx_sym_valid_o && rx_sym_o == -$past(rx_sym_i))
		else $error("symbol not negated");
	a_sym_pass: assert property (rx_sym_valid_i && !inv_ff |=> rx_sym_valid_o && rx_sym_o == $past(rx_sym_i))
		else $error("symbol altered");
	a_busy_ed: assert property (ccc_ff[7:6] == 2'h2 |=> channel_busy_o == $past(ed_hit))
		else $error("energy busy wrong");
	a_busy_both: assert property (ccc_ff[7:6] == 2'h3 |=> channel_busy_o == ($past(ed_hit) && $past(cs_hit)))
		else $error("combined busy wrong");
	a_busy_cs: assert property (!ccc_ff[7] |=> channel_busy_o == $past(cs_hit))
		else $error("carrier busy wrong");
	cover property (bit_tick_o && high_rate_o);
	cover property (rx_sym_valid_o && inv_ff);
	cover property (channel_busy_o && ccc_ff[7:6] == 2'h3);
endmodule
bind bbc_config bbc_config_asserts #(.SYM_W(SYM_W)) u_chk (.*);

// File: tb/bbc_config_tb.sv
`timescale 1ns/1ps
`include "bbc_params.svh"
module bbc_config_tb;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, rx_sym_valid_i = 0;
	logic rx_sym_valid_o, channel_busy_o, high_rate_o, bit_tick_o;
	logic [9:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hf, cs_level_i = '0, wsel = 4'hf;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
	logic signed [7:0] rx_sym_i = '0, rx_sym_o;
	logic [7:0] ed_level_i = '0, ed_threshold_i = 8'h80;
	int n_fail = 0, tests_run = 0;
	bbc_config uut
	(
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rx_sym_i(rx_sym_i), .rx_sym_valid_i(rx_sym_valid_i),
		.rx_sym_o(rx_sym_o), .rx_sym_valid_o(rx_sym_valid_o),
		.cs_level_i(cs_level_i), .ed_level_i(ed_level_i), .ed_threshold_i(ed_threshold_i),
		.channel_busy_o(channel_busy_o), .high_rate_o(high_rate_o), .bit_tick_o(bit_tick_o)
	);
	always #12.5 clk_i = ~clk_i;
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One classic cycle; waits for ack, bounded
	task wb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, i, 2'h0, wsel, d};
		k = 0;
		do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'h1 && k < 20);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		chk(k < 20, 1);
	endtask
	task per(input int e);
		int k;
		k = 0;
		while (bit_tick_o !== 1'h1 && k < 400) begin @(posedge clk_i); k++; end
		k = 0;
		do begin @(posedge clk_i); k++; end while (bit_tick_o !== 1'h1 && k < 400);
		chk(k, e);
	endtask
	task sym(input logic signed [7:0] x, input logic signed [7:0] e);
		@(posedge clk_i);
		{rx_sym_valid_i, rx_sym_i} <= {1'h1, x};
		@(posedge clk_i);
		rx_sym_valid_i <= 1'h0;
		@(posedge clk_i);
		chk({rx_sym_valid_o, rx_sym_o}, {1'h1, e});
	endtask
	task t_regs;
		wb(0, `BBC_IDX_RATE, 0); chk(rd, 0);
		wb(0, `BBC_IDX_POL, 0); chk(rd, 0);
		wb(0, `BBC_IDX_CCC, 0); chk(rd, 32'h48);
		wb(0, 8'h3a, 0); chk(rd, 0);
		$display("regs done");
	endtask
	// Rate switch; two fast periods so the slow check never sees a flip back
	task t_rate;
		chk(high_rate_o, 0);
		per(160);
		wb(1, `BBC_IDX_RATE, 32'h01);
		wb(0, `BBC_IDX_RATE, 0); chk(rd, 1);
		chk(high_rate_o, 1);
		per(64);
		per(64);
		wb(1, `BBC_IDX_RATE, 0);
		$display("rate done");
	endtask
	task t_sym;
		sym(5, 5);
		wb(1, `BBC_IDX_POL, 32'h04);
		wsel = 4'h0;
		wb(1, `BBC_IDX_POL, 0);
		wsel = 4'hf;
		wb(0, `BBC_IDX_POL, 0); chk(rd, 4);
		sym(5, -5);
		sym(-128, -128);
		wb(1, `BBC_IDX_POL, 0);
		$display("sym done");
	endtask
	// Every mode, threshold 3, inputs on both sides of each strict compare
	task t_cca;
		for (int m = 0; m < 4; m++)
		begin
			wb(1, `BBC_IDX_CCC, {m[1:0], 6'h0c});
			for (int j = 0; j < 4; j++)
			begin
				@(posedge clk_i);
				{cs_level_i, ed_level_i} <= {j[0] ? 4'h4 : 4'h3, j[1] ? 8'h81 : 8'h80};
				repeat (2) @(posedge clk_i);
				chk(channel_busy_o, m == 2 ? j[1] : m == 3 ? j[0] & j[1] : j[0]);
			end
		end
		$display("cca done");
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		t_regs;
		t_rate;
		t_sym;
		t_cca;
		tally_and_finish;
	end
	// Whole run is several hundred cycles
	initial
	begin
		#500000;
		n_fail++;
		tally_and_finish;
	end
endmodule
